// *** hdl/kpm_pkg.sv ***
package kpm_pkg;
	// ****************************************************
	// group letters, in panel order
	// ****************************************************
	typedef enum logic [3:0] {
		GRP_D, GRP_F, GRP_A, GRP_B, GRP_C, GRP_H, GRP_P, GRP_U, GRP_E
	} kpm_group_e;
	localparam logic [3:0] GRP_LAST = 4'h7; // last group reachable by keys
	// ****************************************************
	// ascii first characters of each group
	// ****************************************************
	localparam logic [7:0] CH_D_LC = 8'h64; // lower case d on segments
	localparam logic [7:0] CH_B_LC = 8'h62; // lower case b on segments
	localparam logic [7:0] CH_F = 8'h46;
	localparam logic [7:0] CH_A = 8'h41;
	localparam logic [7:0] CH_C = 8'h43;
	localparam logic [7:0] CH_H = 8'h48;
	localparam logic [7:0] CH_P = 8'h50;
	localparam logic [7:0] CH_U = 8'h55;
	localparam logic [7:0] CH_E = 8'h45;
	// ****************************************************
	// code and value sizes
	// ****************************************************
	localparam int CODE_W = 7; // code number within a group
	localparam int VAL_W = 8; // parameter value width
	localparam logic [6:0] CODE_MAX = 7'h63; // codes 1..99 per group
	localparam logic [6:0] CODE_SPEED_SRC = 7'h01;
	localparam logic [6:0] CODE_RUN_SRC = 7'h02;
	localparam logic [6:0] CODE_BASE_FREQ = 7'h04;
	localparam logic [6:0] CODE_POLES = 7'h04;
	// ****************************************************
	// default encodings
	// ****************************************************
	localparam logic [7:0] SRC_POT = 8'h00;
	localparam logic [7:0] SRC_TERM = 8'h01;
	localparam logic [7:0] SRC_KEYPAD = 8'h02;
	localparam logic [7:0] POLES_DEF = 8'h04;
	localparam logic [7:0] POLES_MIN = 8'h02;
	localparam logic [7:0] POLES_MAX = 8'h08;
	localparam logic [7:0] POLES_STEP = 8'h02;
	localparam logic [7:0] FREQ_US = 8'h3C; // 60 Hz
	localparam logic [7:0] FREQ_EU = 8'h32; // 50 Hz
	localparam logic [7:0] FREQ_MAX = 8'h90; // 400 Hz not representable
	localparam logic [7:0] VAL_MAX = 8'hFF;
	// ****************************************************
	// key repeat timing
	// ****************************************************
	localparam int CLK_MHZ = 125;
	localparam int REPEAT_MS = 100; // auto step period while held
	localparam int REPEAT_CYC = REPEAT_MS * CLK_MHZ * 1000;
	localparam int DELAY_MS = 500; // wait before auto stepping
	localparam int DELAY_CYC = DELAY_MS * CLK_MHZ * 1000;
	// ****************************************************
	// menu levels
	// ****************************************************
	typedef enum logic [1:0] {
		LV_GROUP, LV_CODE, LV_VALUE, LV_ERROR
	} kpm_level_e;
endpackage

// *** hdl/kpm_key_sync.sv ***
`timescale 1ns/1ps
// ****************************************************
// key conditioner: three flops, press pulse, held repeat
// ****************************************************
module kpm_key_sync #(
	parameter int DELAY = 62500000,
	parameter int PERIOD = 12500000
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// raw key pin, high when pressed
	input wire logic keyPin,
	// conditioned outputs
	output logic keyStep,
	output logic keyPress
);
	logic [2:0] sync_ff; // three stage synchroniser
	logic [2:0] nxt_sync;
	logic level_ff; // accepted key level
	logic nxt_level;
	logic [31:0] cnt_ff; // hold timer
	logic [31:0] nxt_cnt;
	logic step_ff;
	logic nxt_step;
	logic press_ff;
	logic nxt_press;

	// next state of the conditioner
	always_comb begin
		nxt_sync = {sync_ff[1:0], keyPin};
		nxt_level = level_ff;
		nxt_cnt = cnt_ff;
		nxt_step = 1'b0;
		nxt_press = 1'b0;
		// change counts once stage two and three agree
		if (sync_ff[1] == sync_ff[2]) begin
			nxt_level = sync_ff[2];
		end
		if (nxt_level && !level_ff) begin
			// fresh press: one step now
			nxt_step = 1'b1;
			nxt_press = 1'b1;
			nxt_cnt = DELAY;
		end else if (nxt_level) begin
			// held: step repeatedly
			if (cnt_ff == 32'h0000_0000) begin
				nxt_step = 1'b1;
				nxt_cnt = PERIOD;
			end else begin
				nxt_cnt = cnt_ff - 32'h0000_0001;
			end
		end else begin
			nxt_cnt = 32'h0000_0000;
		end
	end

	// registers of the conditioner
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_ff <= 3'h0;
			level_ff <= 1'b0;
			cnt_ff <= 32'h0000_0000;
			step_ff <= 1'b0;
			press_ff <= 1'b0;
		end else begin
			sync_ff <= nxt_sync;
			level_ff <= nxt_level;
			cnt_ff <= nxt_cnt;
			step_ff <= nxt_step;
			press_ff <= nxt_press;
		end
	end

	assign keyStep = step_ff;
	assign keyPress = press_ff;
endmodule

// *** hdl/kpm_menu.sv ***
`timescale 1ns/1ps
// What this block does
// - codes grouped by first character, 3-4 chars
// - entering monitoring group selects Monitor mode
// - entering editable group selects Program mode
// - edit only in Program; indicator lit
// - fault shows error group code automatically
// - fine-tuning b and monitor d letters lower case
// - held up/down keeps stepping
// - speed source 0 pot,1 terminals,2 keypad
// - run source 1 terminals, 2 keypad
// - stored keypad run source lights run enable
// - pole count 2,4,6,8; default 4
// - store saves value, back to list
// - stored values change only on store
// - power cycle forces no menu state
// - base frequency default 60 US, 50 EU
// - store writes value to nonvolatile memory
module kpm_menu
	import kpm_pkg::*;
#(
	parameter bit EURO = 1'b0, // selects 50 Hz default
	parameter int DELAY = DELAY_CYC,
	parameter int PERIOD = REPEAT_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// front panel keys, high when pressed
	input wire logic keyFunc,
	input wire logic keyUp,
	input wire logic keyDown,
	input wire logic keyStore,
	// fault report from the drive
	input wire logic faultEvent,
	input wire logic [6:0] faultCode,
	// indicators and display
	output logic programIndicator,
	output logic runEnable,
	output logic [7:0] dispLetter,
	output logic [6:0] dispCode,
	output logic [7:0] dispValue,
	output logic [1:0] dispLevel,
	// nonvolatile write port
	output logic nvWrite,
	output logic [3:0] nvGroup,
	output logic [6:0] nvCode,
	output logic [7:0] nvData,
	// live settings
	output logic [7:0] speedSourceSetting,
	output logic [7:0] runSourceSetting,
	output logic [7:0] baseFrequencySetting,
	output logic [7:0] poleCountSetting
);
	import kpm_pkg::*;
	// ****************************************************
	// key conditioning
	// ****************************************************
	logic fStep, uStep, dStep, sStep; // one cycle key strobes
	kpm_key_sync #(.DELAY(1), .PERIOD(1)) uFunc (.clk(clk), .rst_n(rst_n),
		.keyPin(keyFunc), .keyStep(), .keyPress(fStep));
	kpm_key_sync #(.DELAY(DELAY), .PERIOD(PERIOD)) uUp (.clk(clk),
		.rst_n(rst_n), .keyPin(keyUp), .keyStep(uStep), .keyPress());
	kpm_key_sync #(.DELAY(DELAY), .PERIOD(PERIOD)) uDown (.clk(clk),
		.rst_n(rst_n), .keyPin(keyDown), .keyStep(dStep), .keyPress());
	kpm_key_sync #(.DELAY(1), .PERIOD(1)) uStore (.clk(clk), .rst_n(rst_n),
		.keyPin(keyStore), .keyStep(), .keyPress(sStep));

	// ****************************************************
	// menu state
	// ****************************************************
	kpm_group_e grp_ff, nxt_grp; // current group
	kpm_level_e lvl_ff, nxt_lvl; // current depth
	logic [6:0] code_ff, nxt_code; // code within group
	logic [7:0] edit_ff, nxt_edit; // value being edited
	logic prog_ff, nxt_prog; // program mode
	logic [7:0] spd_ff, nxt_spd, run_ff, nxt_run, frq_ff, nxt_frq;
	logic [7:0] pol_ff, nxt_pol;
	logic runEn_ff, nxt_runEn;
	logic nvw_ff, nxt_nvw;
	logic [7:0] gen_ff [0:7]; // other stored values, one per group
	logic [7:0] nxt_gen [0:7];
	logic [7:0] letter_ff, nxt_letter;
	logic [7:0] stored; // stored value at the cursor
	logic [7:0] upV, dnV; // edited candidates

	// stored value of the code under the cursor
	always_comb begin
		stored = gen_ff[grp_ff[2:0]];
		if (grp_ff == GRP_A && code_ff == CODE_SPEED_SRC) begin
			stored = spd_ff;
		end else if (grp_ff == GRP_A && code_ff == CODE_RUN_SRC) begin
			stored = run_ff;
		end else if (grp_ff == GRP_A && code_ff == CODE_BASE_FREQ) begin
			stored = frq_ff;
		end else if (grp_ff == GRP_H && code_ff == CODE_POLES) begin
			stored = pol_ff;
		end
	end

	// legal step up and down of the edited value
	always_comb begin
		upV = (edit_ff == VAL_MAX) ? edit_ff : edit_ff + 8'h01;
		dnV = (edit_ff == 8'h00) ? edit_ff : edit_ff - 8'h01;
		if (grp_ff == GRP_A && code_ff == CODE_SPEED_SRC) begin
			upV = (edit_ff >= SRC_KEYPAD) ? SRC_KEYPAD : upV;
		end else if (grp_ff == GRP_A && code_ff == CODE_RUN_SRC) begin
			upV = (edit_ff >= SRC_KEYPAD) ? SRC_KEYPAD : upV;
			dnV = (edit_ff <= SRC_TERM) ? SRC_TERM : dnV;
		end else if (grp_ff == GRP_A && code_ff == CODE_BASE_FREQ) begin
			upV = (edit_ff >= FREQ_MAX) ? FREQ_MAX : upV;
		end else if (grp_ff == GRP_H && code_ff == CODE_POLES) begin
			upV = (edit_ff >= POLES_MAX) ? POLES_MAX : edit_ff + POLES_STEP;
			dnV = (edit_ff <= POLES_MIN) ? POLES_MIN : edit_ff - POLES_STEP;
		end
	end

	// navigation, editing and storing
	always_comb begin
		nxt_grp = grp_ff;
		nxt_lvl = lvl_ff;
		nxt_code = code_ff;
		nxt_edit = edit_ff;
		nxt_spd = spd_ff;
		nxt_run = run_ff;
		nxt_frq = frq_ff;
		nxt_pol = pol_ff;
		nxt_gen = gen_ff;
		nxt_nvw = 1'b0;
		if (faultEvent) begin
			// error code shown with no key action
			nxt_grp = GRP_E;
			nxt_lvl = LV_ERROR;
			nxt_code = faultCode;
		end else begin
			case (lvl_ff)
			LV_GROUP: begin
				if (fStep) begin
					nxt_lvl = LV_CODE;
					nxt_code = 7'h01;
				end else if (uStep) begin
					nxt_grp = (grp_ff == GRP_D) ? kpm_group_e'(GRP_LAST)
						: kpm_group_e'(grp_ff - 4'h1);
				end else if (dStep) begin
					nxt_grp = (grp_ff == kpm_group_e'(GRP_LAST)) ? GRP_D
						: kpm_group_e'(grp_ff + 4'h1);
				end
			end
			LV_CODE: begin
				if (fStep) begin
					nxt_lvl = LV_VALUE;
					nxt_edit = stored;
				end else if (uStep && code_ff != CODE_MAX) begin
					nxt_code = code_ff + 7'h01;
				end else if (dStep && code_ff != 7'h01) begin
					nxt_code = code_ff - 7'h01;
				end else if (sStep) begin
					nxt_lvl = LV_GROUP;
				end
			end
			LV_VALUE: begin
				if (sStep || fStep) begin // leaving wins over a step
					nxt_lvl = LV_CODE;
				end else if (prog_ff && uStep) begin
					nxt_edit = upV;
				end else if (prog_ff && dStep) begin
					nxt_edit = dnV;
				end
				if (sStep && prog_ff) begin
					// commit only here; all else leaves storage alone
					nxt_nvw = 1'b1;
					if (grp_ff == GRP_A && code_ff == CODE_SPEED_SRC) begin
						nxt_spd = edit_ff;
					end else if (grp_ff == GRP_A && code_ff == CODE_RUN_SRC) begin
						nxt_run = edit_ff;
					end else if (grp_ff == GRP_A && code_ff == CODE_BASE_FREQ) begin
						nxt_frq = edit_ff;
					end else if (grp_ff == GRP_H && code_ff == CODE_POLES) begin
						nxt_pol = edit_ff;
					end else begin
						nxt_gen[grp_ff[2:0]] = edit_ff;
					end
				end
			end
			LV_ERROR: begin
				// any key returns to the group list
				if (fStep || uStep || dStep || sStep) begin
					nxt_lvl = LV_GROUP;
					nxt_grp = GRP_D;
				end
			end
			default: nxt_lvl = LV_GROUP;
			endcase
		end
	end

	// mode, run enable and display letter follow the state
	always_comb begin
		// monitor groups clear program mode, the rest set it
		nxt_prog = !(nxt_grp == GRP_D || nxt_grp == GRP_U
			|| nxt_grp == GRP_E);
		nxt_runEn = (nxt_run == SRC_KEYPAD);
		case (nxt_grp)
		GRP_D: nxt_letter = CH_D_LC;
		GRP_B: nxt_letter = CH_B_LC;
		GRP_F: nxt_letter = CH_F;
		GRP_A: nxt_letter = CH_A;
		GRP_C: nxt_letter = CH_C;
		GRP_H: nxt_letter = CH_H;
		GRP_P: nxt_letter = CH_P;
		GRP_U: nxt_letter = CH_U;
		default: nxt_letter = CH_E;
		endcase
	end

	// registers; reset is the power-on load, no edit state forced
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			grp_ff <= GRP_D;
			lvl_ff <= LV_GROUP;
			code_ff <= 7'h01;
			edit_ff <= 8'h00;
			prog_ff <= 1'b0;
			spd_ff <= SRC_TERM;
			run_ff <= SRC_TERM;
			frq_ff <= EURO ? FREQ_EU : FREQ_US;
			pol_ff <= POLES_DEF;
			runEn_ff <= 1'b0;
			nvw_ff <= 1'b0;
			letter_ff <= CH_D_LC;
			for (int i = 0; i < 8; i++) begin
				gen_ff[i] <= 8'h00;
			end
		end else begin
			grp_ff <= nxt_grp;
			lvl_ff <= nxt_lvl;
			code_ff <= nxt_code;
			edit_ff <= nxt_edit;
			prog_ff <= nxt_prog;
			spd_ff <= nxt_spd;
			run_ff <= nxt_run;
			frq_ff <= nxt_frq;
			pol_ff <= nxt_pol;
			runEn_ff <= nxt_runEn;
			nvw_ff <= nxt_nvw;
			letter_ff <= nxt_letter;
			gen_ff <= nxt_gen;
		end
	end

	// ****************************************************
	// outputs
	// ****************************************************
	assign programIndicator = prog_ff;
	assign runEnable = runEn_ff;
	assign dispLetter = letter_ff;
	assign dispCode = code_ff;
	assign dispValue = edit_ff;
	assign dispLevel = lvl_ff;
	assign nvWrite = nvw_ff;
	assign nvGroup = grp_ff;
	assign nvCode = code_ff;
	assign nvData = edit_ff;
	assign speedSourceSetting = spd_ff;
	assign runSourceSetting = run_ff;
	assign baseFrequencySetting = frq_ff;
	assign poleCountSetting = pol_ff;

	// ****************************************************
	// checks
	// ****************************************************
	a_monitor_lamp_off: assert property (@(posedge clk) disable iff (!rst_n)
		(grp_ff == GRP_D) |-> !programIndicator)
		else $error("program indicator lit in monitor group");
	a_program_lamp_on: assert property (@(posedge clk) disable iff (!rst_n)
		(grp_ff == GRP_A || grp_ff == GRP_H) |-> programIndicator)
		else $error("program indicator dark in editable group");
	a_fault_shows: assert property (@(posedge clk) disable iff (!rst_n)
		faultEvent |=> (grp_ff == GRP_E && lvl_ff == LV_ERROR))
		else $error("fault did not show error code");
	a_store_only: assert property (@(posedge clk) disable iff (!rst_n)
		!nvw_ff |-> $stable(pol_ff) && $stable(run_ff))
		else $error("setting changed without store");
	a_poles_legal: assert property (@(posedge clk) disable iff (!rst_n)
		pol_ff inside {8'h02, 8'h04, 8'h06, 8'h08})
		else $error("illegal pole count");
	a_run_enable: assert property (@(posedge clk) disable iff (!rst_n)
		runEnable == (run_ff == SRC_KEYPAD))
		else $error("run enable not lit for keypad source");
	a_store_returns: assert property (@(posedge clk) disable iff (!rst_n)
		(lvl_ff == LV_VALUE && sStep && !faultEvent) |=> lvl_ff == LV_CODE
		&& nvWrite == prog_ff)
		else $error("store did not return to list");
	a_speed_range: assert property (@(posedge clk) disable iff (!rst_n)
		spd_ff <= SRC_KEYPAD)
		else $error("speed source out of range");
endmodule

// *** verification/kpm_operator.sv ***
`timescale 1ns/1ps
// ****************************************************
// operator model: presses one front panel key at a time
// ****************************************************
module kpm_operator (
	// clock
	input wire logic clk,
	// key pins, high while pressed
	output logic keyFunc,
	output logic keyUp,
	output logic keyDown,
	output logic keyStore
);
	// all keys idle at time zero
	initial begin
		keyFunc = 1'b0;
		keyUp = 1'b0;
		keyDown = 1'b0;
		keyStore = 1'b0;
	end
	// hold one key (0 func, 1 up, 2 down, 3 store), then settle
	task automatic press(input int k, input int hold);
		@(negedge clk);
		keyFunc = (k == 0);
		keyUp = (k == 1);
		keyDown = (k == 2);
		keyStore = (k == 3);
		repeat (hold) @(negedge clk);
		// release all, a pin is never left floating
		keyFunc = 1'b0;
		keyUp = 1'b0;
		keyDown = 1'b0;
		keyStore = 1'b0;
		repeat (12) @(negedge clk);
	endtask
endmodule

// *** verification/kpm_menu_tb.sv ***
`timescale 1ns/1ps
module kpm_menu_tb;
	import kpm_pkg::*;
	// ****************************************************
	// stimulus constants, wiring, expectation queue
	// ****************************************************
	localparam int KF = 0; // func key
	localparam int KU = 1; // up key
	localparam int KD = 2; // down key
	localparam int KS = 3; // store key
	typedef struct packed {
		logic [3:0] grp;
		logic [6:0] code;
		logic [7:0] data;
	} kpm_nv_s;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic faultEvent = 1'b0;
	logic [6:0] faultCode = 7'h00;
	logic keyFunc, keyUp, keyDown, keyStore;
	logic programIndicator, runEnable, nvWrite;
	logic [7:0] dispLetter, dispValue, nvData;
	logic [6:0] dispCode, nvCode;
	logic [1:0] dispLevel;
	logic [3:0] nvGroup;
	logic [7:0] speedSrc, runSrc, baseFreq, poles;
	kpm_nv_s expQ[$]; // expected store writes, oldest first
	kpm_nv_s head;
	int numErrors = 0;
	int testsRun = 0;
	int seed = 82367;
	int n;
	logic [7:0] expPoles;
	// free running 8 ns clock
	always #4 clk = ~clk;
	kpm_operator op (.clk(clk), .keyFunc(keyFunc), .keyUp(keyUp),
		.keyDown(keyDown), .keyStore(keyStore));
	// short repeat counts keep the run brief
	kpm_menu #(.EURO(1'b0), .DELAY(20), .PERIOD(5)) uut (
		.clk(clk), .rst_n(rst_n), .keyFunc(keyFunc), .keyUp(keyUp),
		.keyDown(keyDown), .keyStore(keyStore), .faultEvent(faultEvent),
		.faultCode(faultCode), .programIndicator(programIndicator),
		.runEnable(runEnable), .dispLetter(dispLetter),
		.dispCode(dispCode), .dispValue(dispValue), .dispLevel(dispLevel),
		.nvWrite(nvWrite), .nvGroup(nvGroup), .nvCode(nvCode),
		.nvData(nvData), .speedSourceSetting(speedSrc),
		.runSourceSetting(runSrc), .baseFrequencySetting(baseFreq),
		.poleCountSetting(poles));
	// ****************************************************
	// helpers
	// ****************************************************
	// one compare, counted, reported at once
	task automatic chk(input logic [7:0] g, input logic [7:0] e,
		input string what);
		testsRun++;
		if (g !== e) begin
			numErrors++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, g, e);
		end
	endtask
	// menu position check: level, letter, code
	task automatic pos(input logic [1:0] lv, input logic [7:0] ch,
		input logic [6:0] cd);
		chk({6'h00, dispLevel}, {6'h00, lv}, "level");
		chk(dispLetter, ch, "letter");
		chk({1'b0, dispCode}, {1'b0, cd}, "code");
	endtask
	// short press, single step
	task automatic tap(input int k, input int times);
		repeat (times) op.press(k, 8);
	endtask
	// note one expected store write
	task automatic note(input logic [3:0] g, input logic [6:0] c,
		input logic [7:0] d);
		expQ.push_back({g, c, d});
	endtask
	// verdict and end of run
	task automatic wrapUp;
		if (numErrors == 0 && testsRun > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// ****************************************************
	// store write monitor: oldest note against each pulse
	// ****************************************************
	// sampled on the falling edge, clear of the edge that launches it
	always @(negedge clk) begin
		if (nvWrite === 1'b1) begin
			if (expQ.size() == 0) begin
				chk(8'h00, 8'h01, "unexpected store write");
			end else begin
				head = expQ.pop_front();
				chk({4'h0, nvGroup}, {4'h0, head.grp}, "nv group");
				chk({1'b0, nvCode}, {1'b0, head.code}, "nv code");
				chk(nvData, head.data, "nv data");
			end
		end
	end
	// watchdog, far beyond the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		numErrors++;
		$display("MISMATCH %0t watchdog expired", $time);
		wrapUp();
	end
	// ****************************************************
	// main sequence
	// ****************************************************
	initial begin
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
		// defaults after reset
		pos(LV_GROUP, CH_D_LC, 7'h01);
		chk({7'h00, programIndicator}, 8'h00, "pgm at d");
		chk({7'h00, runEnable}, 8'h00, "run en");
		chk(speedSrc, SRC_TERM, "speed default");
		chk(runSrc, SRC_TERM, "run default");
		chk(baseFreq, FREQ_US, "freq default");
		chk(poles, POLES_DEF, "poles default");
		// into an editable group
		tap(KD, 1);
		pos(LV_GROUP, CH_F, 7'h01);
		chk({7'h00, programIndicator}, 8'h01, "pgm at f");
		tap(KD, 1);
		tap(KF, 1);
		pos(LV_CODE, CH_A, 7'h01);
		tap(KF, 1);
		chk(dispValue, SRC_TERM, "speed shown");
		tap(KD, 1);
		chk(dispValue, SRC_POT, "speed edited");
		chk(speedSrc, SRC_TERM, "not yet stored");
		note(GRP_A, CODE_SPEED_SRC, SRC_POT);
		tap(KS, 1);
		pos(LV_CODE, CH_A, CODE_SPEED_SRC);
		chk(speedSrc, SRC_POT, "speed stored");
		// edit abandoned with func, then stored
		tap(KU, 1);
		tap(KF, 1);
		tap(KU, 1);
		chk(dispValue, SRC_KEYPAD, "run edited");
		tap(KF, 1);
		chk(runSrc, SRC_TERM, "run kept");
		chk({7'h00, runEnable}, 8'h00, "run en off");
		tap(KF, 1);
		chk(dispValue, SRC_TERM, "run reread");
		tap(KU, 1);
		note(GRP_A, CODE_RUN_SRC, SRC_KEYPAD);
		tap(KS, 1);
		chk(runSrc, SRC_KEYPAD, "run stored");
		chk({7'h00, runEnable}, 8'h01, "run en on");
		// base frequency shown with its default
		tap(KU, 2);
		tap(KF, 1);
		chk(dispValue, FREQ_US, "freq shown");
		note(GRP_A, CODE_BASE_FREQ, FREQ_US);
		tap(KS, 1);
		tap(KS, 1);
		pos(LV_GROUP, CH_A, CODE_BASE_FREQ);
		// lower case fine-tuning letter, then motor group
		tap(KD, 1);
		chk(dispLetter, CH_B_LC, "b lower");
		tap(KD, 2);
		tap(KF, 1);
		tap(KU, 3);
		pos(LV_CODE, CH_H, CODE_POLES);
		tap(KF, 1);
		chk(dispValue, POLES_DEF, "poles shown");
		n = $unsigned($random(seed)) % 4;
		tap(KU, n);
		expPoles = (n >= 2) ? POLES_MAX : 8'(POLES_DEF + n * 2);
		note(GRP_H, CODE_POLES, expPoles);
		tap(KS, 1);
		chk(poles, expPoles, "poles stored");
		// held up key keeps stepping codes
		op.press(KU, 50);
		chk({7'h00, (dispCode > 7'h06)}, 8'h01, "auto step");
		// back to monitoring group
		tap(KS, 1);
		tap(KU, 5);
		// edits refused in a monitor group, store writes nothing
		tap(KF, 2);
		chk(dispValue, 8'h00, "d value shown");
		tap(KU, 1);
		chk(dispValue, 8'h00, "d edit refused");
		tap(KS, 2);
		pos(LV_GROUP, CH_D_LC, 7'h01);
		chk({7'h00, programIndicator}, 8'h00, "pgm off d");
		tap(KU, 1);
		chk(dispLetter, CH_U, "user group");
		chk({7'h00, programIndicator}, 8'h00, "pgm off u");
		// fault forces error display, a key leaves it
		@(negedge clk);
		faultCode = 7'($unsigned($random(seed)) % 100);
		faultEvent = 1'b1;
		@(negedge clk);
		faultEvent = 1'b0;
		repeat (8) @(negedge clk);
		pos(LV_ERROR, CH_E, faultCode);
		tap(KF, 1);
		chk({6'h00, dispLevel}, 8'h00, "error left");
		chk(dispLetter, CH_D_LC, "error to d");
		chk(8'(expQ.size()), 8'h00, "writes missing");
		wrapUp();
	end
endmodule
